/* design/imb_level_ctrl.sv */
// Input mix/boost controls and automatic level control for two channels.
// Assumes decimated ADC samples arrive on the system clock with a strobe.
`timescale 1ns/1ns
`default_nettype none
module imb_level_ctrl
    import imb_pkg::*;
#(
    parameter int ATK_NORM_BASE = ATK_NORM_CYC,
    parameter int ATK_LIM_BASE = ATK_LIM_CYC,
    parameter int DCY_NORM_BASE = DCY_NORM_CYC,
    parameter int DCY_LIM_BASE = DCY_LIM_CYC,
    parameter int HLD_BASE = HLD_BASE_CYC
) (
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic ARST_N_IN,
    // AXI4-Lite write channels
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    // AXI4-Lite read channels
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN,
    // Decimated ADC samples
    input wire logic [23:0] ADC_LEFT_IN,
    input wire logic [23:0] ADC_RIGHT_IN,
    input wire logic ADC_VALID_IN,
    // Analog front-end controls
    output logic [8:0] POWER_CTRL_OUT,
    output imb_mix_t MIX_LEFT_OUT,
    output imb_mix_t MIX_RIGHT_OUT,
    output logic [5:0] PGA_GAIN_LEFT_OUT,
    output logic [5:0] PGA_GAIN_RIGHT_OUT
);
    // Slot 0 power, 1-3 level control, 4/5 boost L/R, 6/7 line L/R.
    function automatic logic [3:0] slot_of(input logic [7:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        case (idx)
            IDX_POWER_TWO: slot_of = 4'h0;
            IDX_GAIN_LIMITS: slot_of = 4'h1;
            IDX_TARGET_HOLD: slot_of = 4'h2;
            IDX_ATTACK_DECAY: slot_of = 4'h3;
            IDX_LEFT_BOOST: slot_of = 4'h4;
            IDX_RIGHT_BOOST: slot_of = 4'h5;
            IDX_LEFT_LINE: slot_of = 4'h6;
            IDX_RIGHT_LINE: slot_of = 4'h7;
            IDX_STAT_RIGHT: slot_of = 4'h8;
            IDX_STAT_LEFT: slot_of = 4'h9;
            default: slot_of = 4'hf;
        endcase
    endfunction

    function automatic logic [15:0] abs16(input logic [23:0] s);
        logic [23:0] m;
        m = s[23] ? (~s + 24'h000001) : s;
        abs16 = (m[23:8] == 16'h8000) ? 16'hffff : m[23:8];
    endfunction

    function automatic logic [31:0] interval(input int base,
                                             input logic [3:0] code);
        logic [3:0] c;
        c = (code > TIME_CODE_MAX) ? TIME_CODE_MAX : code;
        interval = 32'(base) << c;
    endfunction

    // Target level in 1.5 dB steps from -22.5 dBFS, 16-bit magnitude.
    function automatic logic [15:0] target_mag(input logic [3:0] lvl);
        case (lvl)
            4'h0: target_mag = 16'h0999;
            4'h1: target_mag = 16'h0b68;
            4'h2: target_mag = 16'h0d8e;
            4'h3: target_mag = 16'h101d;
            4'h4: target_mag = 16'h1326;
            4'h5: target_mag = 16'h16c3;
            4'h6: target_mag = 16'h1b0d;
            4'h7: target_mag = 16'h2027;
            4'h8: target_mag = 16'h2635;
            4'h9: target_mag = 16'h2d6b;
            4'ha: target_mag = 16'h35fa;
            4'hb: target_mag = 16'h4027;
            4'hc: target_mag = 16'h4c3f;
            4'hd: target_mag = 16'h5a9d;
            default: target_mag = 16'h6bb3;
        endcase
    endfunction

    logic [8:0] cfg_q [8];
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [5:0] gain_q [2];
    logic [2:0] stat [2];

    // Shared level-control settings, one set for both channels.
    wire [8:0] lim_reg = cfg_q[1];
    wire [8:0] tgt_reg = cfg_q[2];
    wire [8:0] ad_reg = cfg_q[3];
    wire [5:0] min_code = {lim_reg[MIN_LSB +: 3], 3'h0};
    wire [5:0] max_code = {lim_reg[MAX_LSB +: 3], 3'h7};
    wire [1:0] alc_en = lim_reg[EN_LSB +: 2];
    wire lim_mode = ad_reg[MODE_BIT];
    wire [15:0] tgt_mag = target_mag(tgt_reg[LVL_LSB +: 4]);
    // About 1.5 dB under target: t * (1 - 1/8 - 1/32).
    wire [15:0] low_mag = tgt_mag - (tgt_mag >> 3) - (tgt_mag >> 5);
    wire [3:0] hld_code = tgt_reg[HLD_LSB +: 4];
    wire [31:0] atk_cyc = interval(lim_mode ? ATK_LIM_BASE : ATK_NORM_BASE,
                                   ad_reg[ATK_LSB +: 4]);
    wire [31:0] dcy_cyc = interval(lim_mode ? DCY_LIM_BASE : DCY_NORM_BASE,
                                   ad_reg[DCY_LSB +: 4]);
    wire [31:0] emg_cyc = interval(ATK_LIM_BASE, 4'h0);
    wire [31:0] hld_cyc = (hld_code == 4'h0) ? 32'h0 :
                          interval(HLD_BASE, (hld_code > TIME_CODE_MAX ?
                                   TIME_CODE_MAX : hld_code) - 4'h1);
    wire [23:0] samp [2];
    assign samp[0] = ADC_RIGHT_IN;
    assign samp[1] = ADC_LEFT_IN;

    // Register bus. A write is taken when address and data are both valid,
    // which keeps one response in flight without a separate holding slot.
    wire [3:0] wslot = slot_of(S_AXI_AWADDR_IN);
    wire [3:0] rslot = slot_of(S_AXI_ARADDR_IN);
    wire wr_go = S_AXI_AWVALID_IN && S_AXI_WVALID_IN && !bvalid_q;
    wire wr_ok = wslot < 4'h8;
    wire rd_go = S_AXI_ARVALID_IN && !rvalid_q;
    wire [8:0] wmask = {S_AXI_WSTRB_IN[1], {8{S_AXI_WSTRB_IN[0]}}};
    wire [8:0] rd_word = (rslot < 4'h8) ? cfg_q[rslot[2:0]] :
                         (rslot == 4'h8) ? {stat[0], gain_q[0]} :
                         (rslot == 4'h9) ? {stat[1], gain_q[1]} : 9'h000;
    assign S_AXI_AWREADY_OUT = wr_go;
    assign S_AXI_WREADY_OUT = wr_go;
    assign S_AXI_BVALID_OUT = bvalid_q;
    assign S_AXI_BRESP_OUT = bresp_q;
    assign S_AXI_ARREADY_OUT = !rvalid_q;
    assign S_AXI_RVALID_OUT = rvalid_q;
    assign S_AXI_RRESP_OUT = rresp_q;
    assign S_AXI_RDATA_OUT = rdata_q;

    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cfg_q[0] <= RST_POWER_TWO;
            cfg_q[1] <= RST_GAIN_LIMITS;
            cfg_q[2] <= RST_TARGET_HOLD;
            cfg_q[3] <= RST_ATTACK_DECAY;
            cfg_q[4] <= RST_BOOST;
            cfg_q[5] <= RST_BOOST;
            cfg_q[6] <= RST_LINE;
            cfg_q[7] <= RST_LINE;
        end else if (wr_go && wr_ok) begin
            cfg_q[wslot[2:0]] <= (cfg_q[wslot[2:0]] & ~wmask) |
                                 (S_AXI_WDATA_IN[8:0] & wmask);
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0;
        end else begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY_IN) begin
                bvalid_q <= 1'b0;
            end
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rresp_q <= (rslot == 4'hf) ? RESP_SLVERR : RESP_OKAY;
                rdata_q <= {23'h0, rd_word};
            end else if (S_AXI_RREADY_IN) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Mix/boost controls: slots 4/6 are left, 5/7 right.
    assign POWER_CTRL_OUT = cfg_q[0];
    assign MIX_LEFT_OUT.pga_boost = cfg_q[4][BOOST_BIT];
    assign MIX_LEFT_OUT.pga_mute = !cfg_q[4][UNMUTE_BIT];
    assign MIX_LEFT_OUT.line_gain = cfg_q[6][LINE_LSB +: 3];
    assign MIX_LEFT_OUT.line_mute = cfg_q[6][LINE_LSB +: 3] == 3'h0;
    assign MIX_RIGHT_OUT.pga_boost = cfg_q[5][BOOST_BIT];
    assign MIX_RIGHT_OUT.pga_mute = !cfg_q[5][UNMUTE_BIT];
    assign MIX_RIGHT_OUT.line_gain = cfg_q[7][LINE_LSB +: 3];
    assign MIX_RIGHT_OUT.line_mute = cfg_q[7][LINE_LSB +: 3] == 3'h0;
    assign PGA_GAIN_LEFT_OUT = gain_q[1];
    assign PGA_GAIN_RIGHT_OUT = gain_q[0];

    logic mode_dly_q;
    always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            mode_dly_q <= 1'b0;
        end else begin
            mode_dly_q <= lim_mode;
        end
    end
    wire lim_rise = lim_mode && !mode_dly_q;
    localparam int EMG_WAIT = ATK_LIM_BASE;

    // Channel 0 is right and channel 1 left, matching the enable bits.
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        logic [15:0] peak_q;
        logic [15:0] inst_q;
        logic atk_q;
        logic [5:0] cap_q;
        logic [31:0] hold_q;
        logic [31:0] step_q;
        wire en = alc_en[ch];
        wire [15:0] mag = abs16(samp[ch]);
        wire [15:0] decay = {8'h0, peak_q[15:PEAK_DECAY_SHIFT]} + 16'h1;
        wire [15:0] peak_d = (mag > peak_q) ? mag :
                             (peak_q > decay) ? peak_q - decay : 16'h0;
        wire emerg = en && inst_q > PEAK_LIMIT;
        wire below = peak_q <= low_mag;
        wire hold_ok = hold_q >= hld_cyc;
        wire dn = en && (emerg || atk_q);
        wire up = en && !dn && below && hold_ok;
        wire [5:0] upper = !lim_mode ? max_code :
                           lim_rise ? gain_q[ch] : cap_q;
        wire [31:0] ivl = emerg ? emg_cyc : (dn ? atk_cyc : dcy_cyc);
        wire step = (dn || up) && (step_q >= ivl - 32'h1);
        wire do_dn = step && dn && gain_q[ch] > min_code;
        wire do_up = step && up && gain_q[ch] < upper;
        assign stat[ch] = {hold_ok, emerg, atk_q};

        always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                peak_q <= 16'h0;
                inst_q <= 16'h0;
            end else if (ADC_VALID_IN) begin
                peak_q <= peak_d;
                inst_q <= mag;
            end
        end

        // A sample over target sets attack even in the cycle it would end.
        always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                atk_q <= 1'b0;
            end else if (en && inst_q > tgt_mag) begin
                atk_q <= 1'b1;
            end else if (below || !en) begin
                atk_q <= 1'b0;
            end
        end

        always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                hold_q <= 32'h0;
                step_q <= 32'h0;
            end else begin
                hold_q <= (en && below && !dn) ?
                          (hold_ok ? hold_q : hold_q + 32'h1) : 32'h0;
                step_q <= (!(dn || up) || step) ? 32'h0 : step_q + 32'h1;
            end
        end

        // Disabled channels simply stop stepping and keep their gain.
        always_ff @(posedge CLK_SYS_IN or negedge ARST_N_IN) begin
            if (!ARST_N_IN) begin
                gain_q[ch] <= GAIN_RESET;
                cap_q <= GAIN_RESET;
            end else begin
                if (lim_rise) begin
                    cap_q <= gain_q[ch];
                end
                if (do_dn) begin
                    gain_q[ch] <= gain_q[ch] - 6'h1;
                end else if (do_up) begin
                    gain_q[ch] <= gain_q[ch] + 6'h1;
                end
            end
        end

        sequence s_rise;
            gain_q[ch] > $past(gain_q[ch]);
        endsequence

        a_gain_min_floor: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            $past(do_dn) |-> gain_q[ch] >= min_code)
            else $error("gain stepped below minimum");
        a_gain_max_normal: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            s_rise and !$past(lim_mode) |-> $past(gain_q[ch]) < $past(max_code))
            else $error("gain raised above maximum in normal mode");
        a_limiter_cap_hold: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            s_rise and $past(lim_mode) |-> gain_q[ch] <= $past(cap_q))
            else $error("gain raised above limiter cap");
        a_peak_new_max: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            ADC_VALID_IN && mag > peak_q |=> peak_q == $past(mag))
            else $error("peak not updated to larger sample");
        a_peak_decay_down: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            ADC_VALID_IN && mag <= peak_q && peak_q != 16'h0
            |=> peak_q < $past(peak_q))
            else $error("peak did not decay");
        a_step_one_code: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            gain_q[ch] != $past(gain_q[ch]) |->
            (gain_q[ch] == $past(gain_q[ch]) + 6'h1 ||
             gain_q[ch] == $past(gain_q[ch]) - 6'h1))
            else $error("gain moved by more than one step");
        a_disabled_gain_kept: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            !en [*2] |-> $stable(gain_q[ch]))
            else $error("disabled channel gain changed");
        a_rise_after_hold: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            s_rise |-> $past(hold_ok && below && !emerg))
            else $error("gain rose without hold or under limit");
        a_emerg_ramp_down: assert property (@(posedge CLK_SYS_IN)
            disable iff (!ARST_N_IN)
            emerg && gain_q[ch] > min_code && step_q == 32'h0 && !step
            |-> ##[1:EMG_WAIT] gain_q[ch] < $past(gain_q[ch]) || !emerg)
            else $error("peak limit did not ramp gain down");
    end

    a_pga_mute_bit: assert property (@(posedge CLK_SYS_IN)
        disable iff (!ARST_N_IN)
        wr_go && wr_ok && wslot == 4'h4 && S_AXI_WSTRB_IN[0]
        |=> MIX_LEFT_OUT.pga_mute == !$past(S_AXI_WDATA_IN[UNMUTE_BIT]))
        else $error("left amplifier mute does not follow bit 6");
endmodule
`default_nettype wire

/* shared/imb_pkg.sv */
// Constants and types shared by the input mix/boost and level-control block.
// Assumes a 10 MHz system clock and 9-bit registers on a 32-bit bus.
package imb_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_POWER_TWO = 6'h02;
    localparam logic [5:0] IDX_GAIN_LIMITS = 6'h20;
    localparam logic [5:0] IDX_TARGET_HOLD = 6'h21;
    localparam logic [5:0] IDX_ATTACK_DECAY = 6'h22;
    localparam logic [5:0] IDX_LEFT_BOOST = 6'h2d;
    localparam logic [5:0] IDX_RIGHT_BOOST = 6'h2e;
    localparam logic [5:0] IDX_LEFT_LINE = 6'h2f;
    localparam logic [5:0] IDX_RIGHT_LINE = 6'h30;
    localparam logic [5:0] IDX_STAT_RIGHT = 6'h3e;
    localparam logic [5:0] IDX_STAT_LEFT = 6'h3f;
    // Reset values, in slot order of the configuration array.
    localparam logic [8:0] RST_POWER_TWO = 9'h000;
    localparam logic [8:0] RST_GAIN_LIMITS = 9'h038;
    localparam logic [8:0] RST_TARGET_HOLD = 9'h00b;
    localparam logic [8:0] RST_ATTACK_DECAY = 9'h032;
    localparam logic [8:0] RST_BOOST = 9'h000;
    localparam logic [8:0] RST_LINE = 9'h000;
    // Field positions.
    localparam int MIN_LSB = 0;
    localparam int MAX_LSB = 3;
    localparam int EN_LSB = 7;
    localparam int LVL_LSB = 0;
    localparam int HLD_LSB = 4;
    localparam int ATK_LSB = 0;
    localparam int DCY_LSB = 4;
    localparam int MODE_BIT = 8;
    localparam int UNMUTE_BIT = 6;
    localparam int BOOST_BIT = 8;
    localparam int LINE_LSB = 4;
    // Gain codes are 0.75 dB apart, code 0 is -12 dB.
    localparam logic [5:0] GAIN_RESET = 6'h10;
    localparam logic [15:0] PEAK_LIMIT = 16'h7000;
    localparam int PEAK_DECAY_SHIFT = 8;
    localparam logic [3:0] TIME_CODE_MAX = 4'ha;
    // Timing, in nanoseconds, and the derived cycle counts.
    localparam int CLK_NS = 100;
    localparam int ATK_NORM_NS = 125000;
    localparam int ATK_LIM_NS = 31250;
    localparam int DCY_NORM_NS = 500000;
    localparam int DCY_LIM_NS = 125000;
    localparam int HLD_BASE_NS = 2000000;
    localparam int ATK_NORM_CYC = (ATK_NORM_NS + CLK_NS - 1) / CLK_NS;
    localparam int ATK_LIM_CYC = (ATK_LIM_NS + CLK_NS - 1) / CLK_NS;
    localparam int DCY_NORM_CYC = (DCY_NORM_NS + CLK_NS - 1) / CLK_NS;
    localparam int DCY_LIM_CYC = (DCY_LIM_NS + CLK_NS - 1) / CLK_NS;
    localparam int HLD_BASE_CYC = (HLD_BASE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic pga_boost;
        logic pga_mute;
        logic line_mute;
        logic [2:0] line_gain;
    } imb_mix_t;
endpackage

/* sim/imb_level_ctrl_tb.sv */
// Self-checking bench for the mix/boost and level-control block.
// Assumes short timing parameters, so each gain step takes a few cycles.
`timescale 1ns/1ns
`default_nettype none
module imb_level_ctrl_tb
    import imb_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic bready = 1'b0;
    logic arv = 1'b0;
    logic rready = 1'b0;
    logic [23:0] adc = 24'h0;
    logic adc_v = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [8:0] pwr;
    imb_mix_t mix_l, mix_r;
    logic [5:0] gain_l, gain_r;
    int mismatches = 0;
    int compares = 0;

    imb_level_ctrl #(.ATK_NORM_BASE(4), .ATK_LIM_BASE(2), .DCY_NORM_BASE(8),
        .DCY_LIM_BASE(4), .HLD_BASE(8)) i_imb_level_ctrl (
        .CLK_SYS_IN(clk), .ARST_N_IN(rst_n),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
        .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
        .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wv),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready),
        .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arv),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid),
        .S_AXI_RREADY_IN(rready), .ADC_LEFT_IN(adc), .ADC_RIGHT_IN(adc),
        .ADC_VALID_IN(adc_v), .POWER_CTRL_OUT(pwr), .MIX_LEFT_OUT(mix_l),
        .MIX_RIGHT_OUT(mix_r), .PGA_GAIN_LEFT_OUT(gain_l),
        .PGA_GAIN_RIGHT_OUT(gain_r));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    // Both bus tasks start just after a rising edge and return on one.
    task automatic wr(input logic [5:0] idx, input logic [8:0] d,
                      input logic [1:0] er);
        awaddr <= {idx, 2'b00};
        wdata <= {23'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] e,
                      input logic [31:0] m, input logic [1:0] er);
        araddr <= {idx, 2'b00};
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        chk("rdata", e, rdata & m);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask

    task automatic run(input logic [23:0] s, input int n);
        adc <= s;
        adc_v <= 1'b1;
        repeat (n) @(posedge clk);
        adc_v <= 1'b0;
        // One idle edge so a following run never drives the strobe twice.
        @(posedge clk);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic t_regs();
        rd(IDX_GAIN_LIMITS, 32'h038, '1, RESP_OKAY);
        rd(IDX_TARGET_HOLD, 32'h00b, '1, RESP_OKAY);
        rd(IDX_ATTACK_DECAY, 32'h032, '1, RESP_OKAY);
        rd(6'h10, 32'h0, '1, RESP_SLVERR);
        wr(6'h10, 9'h1ff, RESP_SLVERR);
        wr(IDX_STAT_LEFT, 9'h1ff, RESP_SLVERR);
        wr(IDX_POWER_TWO, 9'h1a5, RESP_OKAY);
        rd(IDX_POWER_TWO, 32'h1a5, '1, RESP_OKAY);
        chk("power", 32'h1a5, {23'h0, pwr});
        chk("mix_l", 32'h18, {26'h0, mix_l});
        chk("gain_l", 32'h10, {26'h0, gain_l});
    endtask

    task automatic t_mix();
        wr(IDX_LEFT_BOOST, 9'h140, RESP_OKAY);
        wr(IDX_RIGHT_BOOST, 9'h100, RESP_OKAY);
        for (int g = 0; g < 8; g++) begin
            wr(IDX_LEFT_LINE, {2'b00, g[2:0], 4'h0}, RESP_OKAY);
            chk("mix_l", {26'h0, 2'b10, g == 0, g[2:0]}, {26'h0, mix_l});
        end
        wr(IDX_RIGHT_LINE, 9'h070, RESP_OKAY);
        chk("mix_r", 32'h37, {26'h0, mix_r});
        rd(IDX_LEFT_BOOST, 32'h140, '1, RESP_OKAY);
        // Lane 0 covers bits 7:0 only, lane 1 covers bit 8 only.
        wstrb <= 4'h1;
        wr(IDX_LEFT_BOOST, 9'h100, RESP_OKAY);
        rd(IDX_LEFT_BOOST, 32'h100, '1, RESP_OKAY);
        wstrb <= 4'h2;
        wr(IDX_LEFT_BOOST, 9'h040, RESP_OKAY);
        wstrb <= 4'hf;
        chk("mix_l", 32'h17, {26'h0, mix_l});
    endtask

    // Loud samples above the peak limit; the minimum gain code is 8.
    task automatic t_enable();
        for (int c = 0; c < 4; c++) begin
            do_reset();
            wr(IDX_GAIN_LIMITS, {c[1:0], 7'h39}, RESP_OKAY);
            run(24'h7fffff, 60);
            chk("gain_l", c[1] ? 32'h8 : 32'h10, {26'h0, gain_l});
            chk("gain_r", c[0] ? 32'h8 : 32'h10, {26'h0, gain_r});
        end
        rd(IDX_STAT_LEFT, 32'h8, 32'h3f, RESP_OKAY);
        wr(IDX_GAIN_LIMITS, 9'h189, RESP_OKAY);
        run(24'h000000, 2500);
        chk("gain_l", 32'hf, {26'h0, gain_l});
    endtask

    // Limiter attack steps twice as often as normal attack.
    task automatic t_attack();
        for (int m = 0; m < 2; m++) begin
            do_reset();
            wr(IDX_GAIN_LIMITS, 9'h1b8, RESP_OKAY);
            wr(IDX_ATTACK_DECAY, {m[0], 8'h32}, RESP_OKAY);
            run(24'h500000, 40);
            chk("atk", 32'h1, {31'h0, gain_l inside {[(m ? 10 : 13) :
                (m ? 12 : 15)]}});
        end
    endtask

    task automatic t_limiter();
        do_reset();
        wr(IDX_GAIN_LIMITS, 9'h1b8, RESP_OKAY);
        wr(IDX_ATTACK_DECAY, 9'h132, RESP_OKAY);
        run(24'h000000, 1000);
        chk("gain_l", 32'h10, {26'h0, gain_l});
        wr(IDX_ATTACK_DECAY, 9'h032, RESP_OKAY);
        run(24'h000000, 300);
        chk("rise", 32'h1, {31'h0, gain_l > 6'h10});
    endtask

    // Hold code 10 delays any rise by 4096 cycles.
    task automatic t_hold();
        do_reset();
        wr(IDX_GAIN_LIMITS, 9'h1b8, RESP_OKAY);
        wr(IDX_TARGET_HOLD, 9'h0ab, RESP_OKAY);
        run(24'h000000, 2000);
        chk("gain_l", 32'h10, {26'h0, gain_l});
        run(24'h000000, 2500);
        chk("rise", 32'h1, {31'h0, gain_l > 6'h10});
    endtask

    task automatic complete_run();
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        complete_run();
    end

    initial begin
        do_reset();
        t_regs();
        t_mix();
        t_enable();
        t_attack();
        t_limiter();
        t_hold();
        complete_run();
    end
endmodule
`default_nettype wire
